//--- clpt_consts.svh
`ifndef CLPT_CONSTS_SVH
`define CLPT_CONSTS_SVH

// Comma characters, control flag set
`define CLPT_COMMA_A      8'h3C
`define CLPT_COMMA_B      8'hBC
`define CLPT_COMMA_C      8'hFC

// Latency counter
`define CLPT_LAT_MAX      20'hFFFFF
`define CLPT_LAT_ZERO     20'h00000

// Pattern selection codes
`define CLPT_PAT_PRBS7    3'h0
`define CLPT_PAT_PRBS23   3'h1
`define CLPT_PAT_PRBS31   3'h2
`define CLPT_PAT_HF       3'h3
`define CLPT_PAT_LF       3'h4
`define CLPT_PAT_MF       3'h5
`define CLPT_PAT_CRPAT_L  3'h6
`define CLPT_PAT_CRPAT_S  3'h7
`define CLPT_PAT_RESET    3'h2

// Fixed pattern words, sent LSB first, period ten bits
`define CLPT_WORD_LF      10'h01F
`define CLPT_WORD_MF      10'h0DF
`define CLPT_WORD_CRS     10'h2B7

// Good bits needed before the checker claims sync
`define CLPT_SYNC_GOOD    6'h20

// Measurement clock: bit clocks per tick for each rate
`define CLPT_DIV_FULL     7'h08
`define CLPT_DIV_HALF     7'h04
`define CLPT_DIV_QUARTER  7'h02
`define CLPT_DIV_EIGHTH   7'h01

`endif

//--- clpt_pkg.sv
package clpt_pkg;

    typedef struct packed {
        logic       ctrl;
        logic [7:0] data;
    } clpt_sym_t;

    typedef enum logic [2:0] {
        CLPT_LOOP_NONE,
        CLPT_LOOP_DEEP_REMOTE,
        CLPT_LOOP_SHALLOW_REMOTE,
        CLPT_LOOP_DEEP_LOCAL,
        CLPT_LOOP_SHALLOW_LOCAL
    } clpt_loop_t;

    typedef enum logic [1:0] {
        CLPT_RATE_FULL,
        CLPT_RATE_HALF,
        CLPT_RATE_QUARTER,
        CLPT_RATE_EIGHTH
    } clpt_rate_t;

    typedef enum logic [1:0] {
        CLPT_SW_IDLE,
        CLPT_SW_RUN,
        CLPT_SW_DONE
    } clpt_sw_state_t;

endpackage

//--- clpt_top.sv
`include "clpt_consts.svh"

module clpt_top (
    // Clock, reset, enable
    input  wire logic                  clk_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  ce_in,
    // Datapath symbols
    input  wire clpt_pkg::clpt_sym_t   line_rx_sym_in,
    input  wire clpt_pkg::clpt_sym_t   host_rx_sym_in,
    output clpt_pkg::clpt_sym_t        line_tx_sym_out,
    output clpt_pkg::clpt_sym_t        host_tx_sym_out,
    // Loopback control and link status
    input  wire clpt_pkg::clpt_loop_t  loop_mode_in,
    input  wire logic                  lane_aligned_in,
    input  wire logic                  host_link_ok_input,
    output logic                       host_link_ok_output,
    output logic                       link_ok_eff_out,
    // Pattern test
    input  wire logic                  pattern_test_enable_pin,
    input  wire logic [1:0]            pat_reg_en_in,
    input  wire logic [2:0]            pat_sel_in,
    input  wire logic                  pat_sel_wr_in,
    input  wire logic [3:0]            pass_sel_in,
    input  wire logic                  line_pat_rx_bit_in,
    input  wire logic                  host_pat_rx_bit_in,
    output logic                       line_pat_tx_bit_out,
    output logic                       host_pat_tx_bit_out,
    output logic [1:0]                 pattern_sync_flag,
    output logic                       pattern_check_ok_pin,
    // Latency stopwatch
    input  wire logic                  sw_start_sel_in,
    input  wire logic                  sw_stop_sel_in,
    input  wire clpt_pkg::clpt_rate_t  sw_rate_in,
    input  wire logic [1:0]            sw_div_in,
    input  wire logic                  sw_use_rcv_in,
    input  wire logic                  rcv_byte_tick_in,
    input  wire logic                  sw_read_lo_in,
    output logic                       sw_done_out,
    output logic [3:0]                 sw_count_hi_out,
    output logic [15:0]                sw_count_lo_out,
    output logic [7:0]                 sw_start_loc_out,
    output logic [7:0]                 sw_stop_loc_out
);

    localparam clpt_pkg::clpt_sym_t IDLE_SYM = 9'h000;

    function automatic logic is_comma(input clpt_pkg::clpt_sym_t s);
        return s.ctrl && (s.data == `CLPT_COMMA_A ||
            s.data == `CLPT_COMMA_B || s.data == `CLPT_COMMA_C);
    endfunction

    function automatic logic prbs_fb(input logic [30:0] s,
                                     input logic [2:0]  sel);
        case (sel)
            `CLPT_PAT_PRBS7, `CLPT_PAT_CRPAT_L: return s[6] ^ s[5];
            `CLPT_PAT_PRBS23:                   return s[22] ^ s[17];
            default:                            return s[30] ^ s[27];
        endcase
    endfunction

    function automatic logic word_bit(input logic [2:0] sel,
                                      input logic [3:0] ph);
        logic [9:0] w;
        case (sel)
            `CLPT_PAT_LF: w = `CLPT_WORD_LF;
            `CLPT_PAT_MF: w = `CLPT_WORD_MF;
            default:      w = `CLPT_WORD_CRS;
        endcase
        w = w >> ph;
        return (sel == `CLPT_PAT_HF) ? ph[0] : w[0];
    endfunction

    function automatic logic is_prbs(input logic [2:0] sel);
        return sel <= `CLPT_PAT_PRBS31 || sel == `CLPT_PAT_CRPAT_L;
    endfunction

    // Reset release and pin synchronisers
    logic rst_s1_q, rst_n;
    logic hok_s1_q, hok_s2_q, pen_s1_q, pen_s2_q;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else if (ce_in) begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            hok_s1_q <= 1'b0;
            hok_s2_q <= 1'b0;
            pen_s1_q <= 1'b0;
            pen_s2_q <= 1'b0;
        end else if (ce_in) begin
            hok_s1_q <= host_link_ok_input;
            hok_s2_q <= hok_s1_q;
            pen_s1_q <= pattern_test_enable_pin;
            pen_s2_q <= pen_s1_q;
        end
    end

    // Loopback datapath
    clpt_pkg::clpt_loop_t mode_q;
    clpt_pkg::clpt_sym_t  lrx_q, hrx_q, line_tx_d, host_tx_d;
    logic                 align_wait_q, line_loop;

    assign line_loop = mode_q == clpt_pkg::CLPT_LOOP_DEEP_REMOTE ||
                       mode_q == clpt_pkg::CLPT_LOOP_SHALLOW_REMOTE;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_q       <= clpt_pkg::CLPT_LOOP_NONE;
            align_wait_q <= 1'b0;
        end else if (ce_in) begin
            mode_q <= loop_mode_in;
            if (loop_mode_in != mode_q) begin
                align_wait_q <= 1'b1;
            end else if (lane_aligned_in) begin
                align_wait_q <= 1'b0;
            end
        end
    end

    always_comb begin
        line_tx_d = hrx_q;
        host_tx_d = lrx_q;
        case (mode_q)
            clpt_pkg::CLPT_LOOP_DEEP_REMOTE: begin
                line_tx_d = lrx_q;
                host_tx_d = lrx_q;
            end
            clpt_pkg::CLPT_LOOP_SHALLOW_REMOTE: begin
                line_tx_d = line_rx_sym_in;
                host_tx_d = lrx_q;
            end
            clpt_pkg::CLPT_LOOP_DEEP_LOCAL: begin
                host_tx_d = hrx_q;
                line_tx_d = hrx_q;
            end
            clpt_pkg::CLPT_LOOP_SHALLOW_LOCAL: begin
                host_tx_d = host_rx_sym_in;
                line_tx_d = IDLE_SYM;
            end
            default: begin
                line_tx_d = hrx_q;
                host_tx_d = lrx_q;
            end
        endcase
        if (align_wait_q && mode_q != clpt_pkg::CLPT_LOOP_NONE) begin
            line_tx_d = IDLE_SYM;
            host_tx_d = IDLE_SYM;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            lrx_q           <= IDLE_SYM;
            hrx_q           <= IDLE_SYM;
            line_tx_sym_out <= IDLE_SYM;
            host_tx_sym_out <= IDLE_SYM;
        end else if (ce_in) begin
            lrx_q           <= line_rx_sym_in;
            hrx_q           <= host_rx_sym_in;
            line_tx_sym_out <= line_tx_d;
            host_tx_sym_out <= host_tx_d;
        end
    end

    // Link-ok selection
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            host_link_ok_output <= 1'b0;
            link_ok_eff_out     <= 1'b0;
        end else if (ce_in) begin
            host_link_ok_output <= lane_aligned_in && !align_wait_q;
            link_ok_eff_out     <= line_loop ? host_link_ok_output
                                             : hok_s2_q;
        end
    end

    // Pattern generators and checkers, index 0 host, 1 line
    logic [2:0]  pat_sel_q;
    logic [2:0]  side_sel  [2];
    logic [1:0]  pat_en;
    logic [1:0]  rx_bit;
    logic [30:0] gen_q     [2];
    logic [30:0] hist_q    [2];
    logic [3:0]  ph_q      [2];
    logic [5:0]  good_q    [2];
    logic [1:0]  err_q;
    logic [1:0]  gen_bit;
    logic [1:0]  exp_bit;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pat_sel_q <= `CLPT_PAT_RESET;
        end else if (ce_in && pat_sel_wr_in) begin
            pat_sel_q <= pat_sel_in;
        end
    end

    assign side_sel[0] = (pat_sel_q > `CLPT_PAT_PRBS31) ?
                         `CLPT_PAT_PRBS31 : pat_sel_q;
    assign side_sel[1] = pat_sel_q;
    assign pat_en      = pat_reg_en_in | {2{pen_s2_q}};
    assign rx_bit      = {line_pat_rx_bit_in, host_pat_rx_bit_in};

    for (genvar i = 0; i < 2; i++) begin : g_side
        assign gen_bit[i] = is_prbs(side_sel[i]) ?
            prbs_fb(gen_q[i], side_sel[i]) : word_bit(side_sel[i], ph_q[i]);
        assign exp_bit[i] = is_prbs(side_sel[i]) ?
            prbs_fb(hist_q[i], side_sel[i]) :
            (side_sel[i] == `CLPT_PAT_HF ? hist_q[i][1] : hist_q[i][9]);

        always_ff @(posedge clk_in or negedge rst_n) begin
            if (!rst_n) begin
                gen_q[i]  <= 31'h7FFFFFFF;
                hist_q[i] <= 31'h00000000;
                ph_q[i]   <= 4'h0;
                good_q[i] <= 6'h00;
                err_q[i]  <= 1'b0;
            end else if (ce_in) begin
                if (!pat_en[i]) begin
                    good_q[i] <= 6'h00;
                    err_q[i]  <= 1'b0;
                end else begin
                    gen_q[i]  <= {gen_q[i][29:0], gen_bit[i]};
                    hist_q[i] <= {hist_q[i][29:0], rx_bit[i]};
                    ph_q[i]   <= (ph_q[i] == 4'h9) ? 4'h0 : ph_q[i] + 4'h1;
                    if (rx_bit[i] != exp_bit[i]) begin
                        good_q[i] <= 6'h00;
                        err_q[i]  <= err_q[i] | pattern_sync_flag[i];
                    end else if (good_q[i] != `CLPT_SYNC_GOOD) begin
                        good_q[i] <= good_q[i] + 6'h01;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            host_pat_tx_bit_out  <= 1'b0;
            line_pat_tx_bit_out  <= 1'b0;
            pattern_sync_flag    <= 2'b00;
            pattern_check_ok_pin <= 1'b0;
        end else if (ce_in) begin
            host_pat_tx_bit_out  <= pat_en[0] & gen_bit[0];
            line_pat_tx_bit_out  <= pat_en[1] & gen_bit[1];
            pattern_sync_flag[0] <= good_q[0] == `CLPT_SYNC_GOOD;
            pattern_sync_flag[1] <= good_q[1] == `CLPT_SYNC_GOOD;
            pattern_check_ok_pin <= pat_en[pass_sel_in[3]] &&
                                    !err_q[pass_sel_in[3]];
        end
    end

    // Latency stopwatch tick generation
    logic [6:0] pre_q, period;
    logic       tick;

    always_comb begin
        case (sw_rate_in)
            clpt_pkg::CLPT_RATE_FULL:    period = `CLPT_DIV_FULL;
            clpt_pkg::CLPT_RATE_HALF:    period = `CLPT_DIV_HALF;
            clpt_pkg::CLPT_RATE_QUARTER: period = `CLPT_DIV_QUARTER;
            default:                     period = `CLPT_DIV_EIGHTH;
        endcase
        period = period << sw_div_in;
    end

    assign tick = sw_use_rcv_in ? rcv_byte_tick_in
                                : (pre_q == 7'h00);

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 7'h00;
        end else if (ce_in) begin
            pre_q <= (pre_q == 7'h00) ? period - 7'h01 : pre_q - 7'h01;
        end
    end

    // Latency stopwatch state
    clpt_pkg::clpt_sw_state_t sw_q;
    logic [19:0]              cnt_q;
    clpt_pkg::clpt_sym_t      start_pt, stop_pt;
    logic                     start_c, stop_c;

    assign start_pt = sw_start_sel_in ? line_tx_sym_out : host_rx_sym_in;
    assign stop_pt  = sw_stop_sel_in  ? host_tx_sym_out : line_rx_sym_in;
    assign start_c  = is_comma(start_pt);
    assign stop_c   = is_comma(stop_pt);

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sw_q             <= clpt_pkg::CLPT_SW_IDLE;
            cnt_q            <= `CLPT_LAT_ZERO;
            sw_done_out      <= 1'b0;
            sw_start_loc_out <= 8'h00;
            sw_stop_loc_out  <= 8'h00;
        end else if (ce_in) begin
            case (sw_q)
                clpt_pkg::CLPT_SW_IDLE: begin
                    if (!sw_read_lo_in && start_c) begin
                        sw_q             <= clpt_pkg::CLPT_SW_RUN;
                        sw_start_loc_out <= start_pt.data;
                    end
                end
                clpt_pkg::CLPT_SW_RUN: begin
                    if (stop_c) begin
                        sw_q            <= clpt_pkg::CLPT_SW_DONE;
                        sw_done_out     <= 1'b1;
                        sw_stop_loc_out <= stop_pt.data;
                    end else if (sw_read_lo_in) begin
                        sw_q  <= clpt_pkg::CLPT_SW_IDLE;
                        cnt_q <= `CLPT_LAT_ZERO;
                    end else if (tick && cnt_q != `CLPT_LAT_MAX) begin
                        cnt_q <= cnt_q + 20'h00001;
                    end
                end
                clpt_pkg::CLPT_SW_DONE: begin
                    if (sw_read_lo_in) begin
                        sw_q             <= clpt_pkg::CLPT_SW_IDLE;
                        cnt_q            <= `CLPT_LAT_ZERO;
                        sw_done_out      <= 1'b0;
                        sw_start_loc_out <= 8'h00;
                        sw_stop_loc_out  <= 8'h00;
                    end
                end
                default: sw_q <= clpt_pkg::CLPT_SW_IDLE;
            endcase
        end
    end

    assign sw_count_hi_out = cnt_q[19:16];
    assign sw_count_lo_out = cnt_q[15:0];

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    property p_link_ok;
        ce_in && line_loop |=>
            link_ok_eff_out == $past(host_link_ok_output);
    endproperty
    a_link_ok: assert property (p_link_ok)
        else $error("link ok not internal in line loopback");

    property p_deep_remote;
        ce_in && mode_q == clpt_pkg::CLPT_LOOP_DEEP_REMOTE &&
            !align_wait_q |=> line_tx_sym_out == $past(lrx_q) &&
            host_tx_sym_out == $past(lrx_q);
    endproperty
    a_deep_remote: assert property (p_deep_remote)
        else $error("deep remote routing wrong");

    property p_shallow_remote;
        ce_in && mode_q == clpt_pkg::CLPT_LOOP_SHALLOW_REMOTE &&
            !align_wait_q |=> line_tx_sym_out == $past(line_rx_sym_in);
    endproperty
    a_shallow_remote: assert property (p_shallow_remote)
        else $error("shallow remote routing wrong");

    property p_deep_local;
        ce_in && mode_q == clpt_pkg::CLPT_LOOP_DEEP_LOCAL &&
            !align_wait_q |=> host_tx_sym_out == $past(hrx_q, 1);
    endproperty
    a_deep_local: assert property (p_deep_local)
        else $error("deep local routing wrong");

    property p_shallow_local;
        ce_in && mode_q == clpt_pkg::CLPT_LOOP_SHALLOW_LOCAL |=>
            line_tx_sym_out == IDLE_SYM;
    endproperty
    a_shallow_local: assert property (p_shallow_local)
        else $error("line output not idle in shallow local");

    property p_align;
        ce_in && loop_mode_in != mode_q &&
            loop_mode_in != clpt_pkg::CLPT_LOOP_NONE ##1 ce_in [*2] |->
            host_tx_sym_out == IDLE_SYM && line_tx_sym_out == IDLE_SYM;
    endproperty
    a_align: assert property (p_align)
        else $error("loop traffic passed before alignment");

    property p_pin_enable;
        ce_in && pen_s2_q |=>
            host_pat_tx_bit_out == $past(gen_bit[0]) &&
            line_pat_tx_bit_out == $past(gen_bit[1]);
    endproperty
    a_pin_enable: assert property (p_pin_enable)
        else $error("enable pin not ORed in");

    property p_hold_result;
        ce_in && sw_q == clpt_pkg::CLPT_SW_DONE && !sw_read_lo_in |=>
            sw_done_out && $stable(cnt_q);
    endproperty
    a_hold_result: assert property (p_hold_result)
        else $error("held result changed before read");

    property p_count;
        ce_in && sw_q == clpt_pkg::CLPT_SW_RUN && !stop_c &&
            !sw_read_lo_in && tick && cnt_q != `CLPT_LAT_MAX |=>
            cnt_q == $past(cnt_q) + 20'h00001;
    endproperty
    a_count: assert property (p_count)
        else $error("counter did not step");

    property p_read_clear;
        ce_in && sw_q == clpt_pkg::CLPT_SW_DONE && sw_read_lo_in |=>
            cnt_q == `CLPT_LAT_ZERO && !sw_done_out &&
            sw_start_loc_out == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("low read did not clear stopwatch");

    c_done: cover property (sw_q == clpt_pkg::CLPT_SW_RUN ##1
                            sw_done_out);
    c_sat: cover property (cnt_q == `CLPT_LAT_MAX);
    c_pass: cover property (pattern_sync_flag[1] && pattern_check_ok_pin);
    c_remote: cover property (mode_q == clpt_pkg::CLPT_LOOP_DEEP_REMOTE &&
                              !align_wait_q);

endmodule

//--- clpt_partner.sv
module clpt_partner (
    // Generated bits from the block
    input  wire logic line_tx_bit_in,
    input  wire logic host_tx_bit_in,
    // Error injection
    input  wire logic flip_in,
    // Bits returned to the checkers
    output logic      line_rx_bit_out,
    output logic      host_rx_bit_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // Serial loop back, both returned bits inverted on demand
    assign line_rx_bit_out = line_tx_bit_in ^ flip_in;
    assign host_rx_bit_out = host_tx_bit_in ^ flip_in;
endmodule

//--- clpt_top_test.sv
module clpt_top_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic                 clk_in = 1'b0;
    logic                 reset_n_in = 1'b0;
    logic                 aligned = 1'b0;
    logic                 pin = 1'b0;
    logic                 sel_wr = 1'b0;
    logic                 flip = 1'b0;
    logic                 use_rcv = 1'b0;
    logic                 rcv_tick = 1'b0;
    logic                 read_lo = 1'b0;
    logic                 hok = 1'b0;
    logic                 pts = 1'b0;
    logic [1:0]           tc = 2'h0;
    logic [1:0]           reg_en = 2'h0;
    logic [1:0]           div = 2'h0;
    logic [2:0]           sel = 3'h0;
    logic [3:0]           pass_sel = 4'h0;
    clpt_pkg::clpt_sym_t  line_rx = 9'h000;
    clpt_pkg::clpt_sym_t  host_rx = 9'h000;
    clpt_pkg::clpt_sym_t  line_tx;
    clpt_pkg::clpt_sym_t  host_tx;
    clpt_pkg::clpt_loop_t mode = clpt_pkg::CLPT_LOOP_NONE;
    clpt_pkg::clpt_rate_t rate = clpt_pkg::CLPT_RATE_EIGHTH;
    logic                 lok_int, lok_eff, lptx, hptx, lprx, hprx, ok, done;
    logic [1:0]           sync;
    logic [3:0]           hi;
    logic [15:0]          lo;
    logic [7:0]           sloc, eloc;
    int                   failures = 0;
    int                   compares = 0;

    always #50 clk_in = ~clk_in;

    // Recovered byte tick, one pulse every four clocks
    always @(posedge clk_in) begin
        tc <= tc + 2'h1;
        rcv_tick <= use_rcv && (tc == 2'h0);
    end

    clpt_partner partner (.line_tx_bit_in(lptx), .host_tx_bit_in(hptx),
        .flip_in(flip), .line_rx_bit_out(lprx), .host_rx_bit_out(hprx));

    clpt_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .ce_in(1'b1),
        .line_rx_sym_in(line_rx), .host_rx_sym_in(host_rx),
        .line_tx_sym_out(line_tx), .host_tx_sym_out(host_tx),
        .loop_mode_in(mode), .lane_aligned_in(aligned),
        .host_link_ok_input(hok), .host_link_ok_output(lok_int),
        .link_ok_eff_out(lok_eff), .pattern_test_enable_pin(pin),
        .pat_reg_en_in(reg_en), .pat_sel_in(sel), .pat_sel_wr_in(sel_wr),
        .pass_sel_in(pass_sel), .line_pat_rx_bit_in(lprx),
        .host_pat_rx_bit_in(hprx), .line_pat_tx_bit_out(lptx),
        .host_pat_tx_bit_out(hptx), .pattern_sync_flag(sync),
        .pattern_check_ok_pin(ok), .sw_start_sel_in(pts),
        .sw_stop_sel_in(pts), .sw_rate_in(rate), .sw_div_in(div),
        .sw_use_rcv_in(use_rcv), .rcv_byte_tick_in(rcv_tick),
        .sw_read_lo_in(read_lo), .sw_done_out(done), .sw_count_hi_out(hi),
        .sw_count_lo_out(lo), .sw_start_loc_out(sloc),
        .sw_stop_loc_out(eloc));

    task automatic check(input string name, input logic [19:0] seen, exp);
        #1;
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic put(input bit on_line, input logic [8:0] s);
        @(posedge clk_in);
        if (on_line) line_rx <= s;
        else host_rx <= s;
        @(posedge clk_in);
        line_rx <= 9'h000;
        host_rx <= 9'h000;
    endtask

    task automatic sw(input clpt_pkg::clpt_rate_t r, input logic [1:0] d,
                      input logic u, input int n, input int e);
        int i;
        @(posedge clk_in);
        rate <= r;
        div <= d;
        use_rcv <= u;
        pts <= (d == 2'h2);
        put(0, 9'h13C);
        cyc(n - 2);
        put(1, 9'h1BC);
        for (i = 0; i < 300 && done !== 1'b1; i++) @(posedge clk_in);
        if (done !== 1'b1) begin
            failures++;
            summarize();
        end
        check("sw_done", done, 1);
        check("sw_hi", hi, 0);
        check("sw_lo", lo >= e - 1 && lo <= e + 1, 1);
        check("sw_start_loc", sloc, 8'h3C);
        check("sw_stop_loc", eloc, 8'hBC);
        put(0, 9'h1FC);
        cyc(3);
        check("sw_held", lo >= e - 1 && lo <= e + 1, 1);
        @(posedge clk_in) read_lo <= 1'b1;
        @(posedge clk_in) read_lo <= 1'b0;
        cyc(2);
        check("sw_lo_clr", lo, 0);
        check("sw_done_clr", done, 0);
        check("sw_loc_clr", sloc, 0);
    endtask

    initial begin
        cyc(10);
        reset_n_in <= 1'b1;
        cyc(3);
        check("line_tx_rst", line_tx, 0);
        for (int m = 1; m <= 4; m++) begin
            @(posedge clk_in);
            aligned <= 1'b0;
            mode <= clpt_pkg::clpt_loop_t'(m);
            hok <= (m == 4);
            line_rx <= 9'h0A5;
            host_rx <= (m < 3) ? 9'h000 : 9'h03E;
            cyc(4);
            check("line_tx_wait", line_tx, 0);
            check("host_tx_wait", host_tx, 0);
            @(posedge clk_in) aligned <= 1'b1;
            cyc(5);
            check("host_tx", host_tx, (m < 3) ? 9'h0A5 : 9'h03E);
            if (m < 3) begin
                check("line_tx", line_tx, 9'h0A5);
                check("link_ok_eff", lok_eff, 1);
                check("link_ok_int", lok_int, 1);
            end else begin
                check("line_mon", line_tx, (m == 3) ? 9'h3E : 0);
                check("link_ok_loc", lok_eff, m == 4);
            end
        end
        @(posedge clk_in) mode <= clpt_pkg::CLPT_LOOP_NONE;
        line_rx <= 9'h000;
        host_rx <= 9'h000;
        $display("test loopback done");
        for (int c = 0; c < 8; c++) for (int s = 0; s < 2; s++)
            if (s == 1 || c < 3) begin
                @(posedge clk_in) pin <= 1'b0;
                reg_en <= 2'h0;
                sel <= c[2:0];
                sel_wr <= 1'b1;
                pass_sel <= {s[0], 3'h0};
                @(posedge clk_in) sel_wr <= 1'b0;
                cyc(2);
                @(posedge clk_in);
                if (c[0]) reg_en[s] <= 1'b1;
                else pin <= 1'b1;
                cyc(80);
                check("sync", sync[s], 1);
                check("pass_ok", ok, 1);
                @(posedge clk_in) flip <= 1'b1;
                @(posedge clk_in) flip <= 1'b0;
                cyc(4);
                check("pass_err", ok, 0);
            end
        @(posedge clk_in) pin <= 1'b0;
        reg_en <= 2'h0;
        $display("test pattern done");
        put(0, 9'h11C);
        put(0, 9'h03C);
        put(1, 9'h1BC);
        cyc(3);
        check("sw_no_start", done, 0);
        check("sw_zero", lo, 0);
        sw(clpt_pkg::CLPT_RATE_EIGHTH, 2'h0, 1'b0, 40, 40);
        sw(clpt_pkg::CLPT_RATE_FULL, 2'h1, 1'b0, 160, 10);
        sw(clpt_pkg::CLPT_RATE_HALF, 2'h2, 1'b0, 160, 10);
        sw(clpt_pkg::CLPT_RATE_QUARTER, 2'h3, 1'b1, 40, 10);
        $display("test stopwatch done");
        summarize();
    end
endmodule
